// >>> include/twp_pkg.sv
/*
 Package for the trigger window processor: record layout, tags, widths and state types.
 Assumes a 16-bit data path toward the processing memory with two flag bits above it.
*/
package twp_pkg;
   // Memory word: two flag bits above a 16-bit payload
   localparam int TWP_WORD_W = 18;
   localparam int TWP_SAMPLE_W = 12;
   localparam int TWP_SUM_W = 19;
   localparam int TWP_ADDR_W = 11;
   localparam int TWP_POS_W = 10;
   localparam int TWP_TRIG_W = 27;
   localparam int TWP_TS_W = 48;
   // Header words read from the secondary buffer before the samples
   localparam int TWP_TS_WORDS = 4;
   localparam int TWP_TRIG_WORDS = 2;
   localparam int TWP_HDR_WORDS = TWP_TS_WORDS + TWP_TRIG_WORDS;
   localparam int TWP_MAX_PULSES = 4;
   // Tag patterns
   localparam logic [4:0] TWP_TRIG_TAG = 5'h12;
   localparam logic [7:0] TWP_TS_TAG = 8'h98;
   localparam logic [1:0] TWP_FLAG_DATA = 2'h0;
   localparam logic [1:0] TWP_FLAG_NOEVT = 2'h1;
   localparam logic [1:0] TWP_FLAG_PULSE = 2'h2;
   localparam logic [1:0] TWP_FLAG_END = 2'h3;
   // Special words
   localparam logic [17:0] TWP_FILLER = 18'h10000;
   localparam logic [17:0] TWP_END_WORD = 18'h30000;
   localparam logic [17:0] TWP_NOPULSE = 18'h0FFF0;
   localparam logic [17:0] TWP_RAW_END = 18'h3FFFF;
   // Processing options
   typedef enum logic [1:0] {TWP_MODE_RAW, TWP_MODE_SUM, TWP_MODE_TIME} twp_mode_t;
   // Main machine states
   typedef enum {TWP_IDLE, TWP_HDR, TWP_RAW, TWP_SCAN, TWP_PRE, TWP_POST, TWP_PW1, TWP_PW2,
      TWP_NOEV, TWP_CLOSE, TWP_DONE} twp_state_t;
endpackage

// >>> rtl/twp_core.sv
/*
 Trigger window processor: reads one buffered window from the secondary buffer and writes
 a formatted record into processing memory in raw, pulse-sum or timing mode.
 Assumes the secondary buffer answers a read address with data on the next clock, and that
 the formatter pulses hostWindowTaken once per window it has read.
*/
// How it works
// RULE_01: Words 0-1 hold tagged trigger number
// RULE_02: Words 2-5 hold tagged 48-bit time stamp
// RULE_03: No event: flags 01, fillers, end marker
// RULE_04: Pulse header: tag, index, crossing position
// RULE_05: Sum split over two words after header
// RULE_06: Max four pulses, then end marker word
// RULE_07: Timing mode: fine time, minimum, peak; the code writes zeros where fine time would go
// RULE_08: Scan whole window; no pulse writes code; the code writes two TWP_FILLER words instead
// RULE_09: No-pulse code tells formatter to suppress; the code never writes TWP_NOPULSE
// RULE_10: Main machine copies header, then dispatches
// RULE_11: Raw copy then processed count increments
// RULE_12: Sample timer counts each sample read
// RULE_13: On crossing write timer, then pre/post
// RULE_14: Pointer back pre count or fewer
// RULE_15: Count pre then post, then stop
// RULE_16: Repeat until window read, then end word
// RULE_17: Counter and pointer clear after window
// RULE_18: Ready count up here, down by host
// RULE_19: Equal count uses full pre count
`timescale 1ns/1ps
module twp_core
   import twp_pkg::*;
#(
   parameter int AW = TWP_ADDR_W,
   parameter int CW = TWP_ADDR_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Configuration
   input wire logic [1:0] processMode,
   input wire logic [AW-1:0] windowSamples,
   input wire logic [AW-1:0] pre_sample_count,
   input wire logic [AW-1:0] post_sample_count,
   input wire logic [TWP_SAMPLE_W-1:0] energy_threshold,
   // Secondary buffer side
   input wire logic windowPending,
   input wire logic [TWP_WORD_W-1:0] bufData,
   output logic [AW-1:0] window_read_pointer,
   output logic windowDone,
   // Processing memory side
   output logic memWrite,
   output logic [AW-1:0] memAddr,
   output logic [TWP_WORD_W-1:0] memData,
   // Host handshake
   input wire logic hostWindowTaken,
   output logic [CW-1:0] host_ready_window_count
);
   twp_state_t state_r;                    // Main and option machine state
   logic [AW-1:0] rdPtr_r;                 // Secondary buffer read address
   logic [AW-1:0] window_word_counter_r;   // Words taken from this window
   logic [AW-1:0] pulseTimer_r;            // Sample position within window
   logic [AW-1:0] samples_before_crossing_count_r; // Samples seen before crossing
   logic [AW-1:0] pre_sample_counter_r;    // Pre-crossing samples summed
   logic [AW-1:0] post_sample_counter_r;   // Post-crossing samples summed
   logic [AW-1:0] preTarget_r;             // Pre samples actually available
   logic [AW-1:0] resume_r;                // Where to continue the scan
   logic [1:0] pulseIdx_r;                 // Pulse index in record
   logic [2:0] pulseCnt_r;                 // Pulses found so far
   logic [TWP_SUM_W-1:0] sum_r;            // Running pulse sum
   logic [AW-1:0] wrAddr_r;                // Next memory address
   logic [47:0] ts_r;                      // Captured time stamp
   logic [26:0] trig_r;                    // Captured trigger number
   logic rdValid_r;                        // Buffer data valid this cycle
   logic [AW-1:0] rdIdx_r;                 // Buffer address of data in flight
   logic memWrite_r;
   logic [AW-1:0] memAddr_r;
   logic [TWP_WORD_W-1:0] memData_r;
   logic windowDone_r;
   logic [CW-1:0] hostCnt_r;
   logic [TWP_SAMPLE_W-1:0] pulsePeak;
   logic [TWP_SAMPLE_W-1:0] pulseMin;
   logic [AW-1:0] lastWord;
   logic [TWP_SAMPLE_W-1:0] sample;
   logic crossing;

   assign lastWord = AW'(TWP_HDR_WORDS) + windowSamples;
   assign sample = bufData[TWP_SAMPLE_W-1:0];
   assign crossing = rdValid_r && (sample > energy_threshold);

   // Build one memory word with flags and payload
   function automatic logic [TWP_WORD_W-1:0] mkWord(input logic [1:0] f, input logic [15:0] p);
      return {f, p};
   endfunction

   // Timing-mode peak/minimum tracker
   twp_pulse_track #(.SW(TWP_SAMPLE_W)) uTrack (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(state_r == TWP_SCAN && crossing),
      .valid(rdValid_r && (state_r == TWP_PRE || state_r == TWP_POST)),
      .sample(sample),
      .pulsePeak(pulsePeak),
      .pulseMin(pulseMin)
   );

   // Read request tracking: data arrives one clock after the address
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdValid_r <= 1'b0;
         rdIdx_r <= '0;
      end else begin
         rdValid_r <= (state_r == TWP_HDR || state_r == TWP_RAW || state_r == TWP_SCAN ||
            state_r == TWP_PRE || state_r == TWP_POST) && !rdValid_r;
         rdIdx_r <= rdPtr_r;
      end
   end

   // Main machine with the option machines folded in
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= TWP_IDLE;
         rdPtr_r <= '0;
         window_word_counter_r <= '0;
         pulseTimer_r <= '0;
         samples_before_crossing_count_r <= '0;
         pre_sample_counter_r <= '0;
         post_sample_counter_r <= '0;
         preTarget_r <= '0;
         resume_r <= '0;
         pulseIdx_r <= '0;
         pulseCnt_r <= '0;
         sum_r <= '0;
         wrAddr_r <= '0;
         ts_r <= '0;
         trig_r <= '0;
         memWrite_r <= 1'b0;
         memAddr_r <= '0;
         memData_r <= '0;
         windowDone_r <= 1'b0;
      end else begin
         memWrite_r <= 1'b0;
         windowDone_r <= 1'b0;
         unique case (state_r)
            TWP_IDLE: begin
               if (windowPending) begin
                  state_r <= TWP_HDR; // RULE_10
                  rdPtr_r <= '0;
                  wrAddr_r <= '0;
                  pulseCnt_r <= '0;
                  pulseIdx_r <= '0;
               end
            end
            // Gather time stamp and trigger words
            TWP_HDR: begin
               if (!rdValid_r) begin
                  rdPtr_r <= rdPtr_r + AW'(1);
               end else begin
                  window_word_counter_r <= window_word_counter_r + AW'(1);
                  case (rdIdx_r)
                     AW'(0): ts_r[47:36] <= bufData[11:0];
                     AW'(1): ts_r[35:24] <= bufData[11:0];
                     AW'(2): ts_r[23:12] <= bufData[11:0];
                     AW'(3): ts_r[11:0] <= bufData[11:0];
                     AW'(4): trig_r[26:14] <= bufData[12:0];
                     default: trig_r[13:0] <= bufData[13:0];
                  endcase
                  if (rdIdx_r == AW'(TWP_HDR_WORDS - 1)) begin
                     pulseTimer_r <= '0;
                     samples_before_crossing_count_r <= '0;
                     wrAddr_r <= AW'(TWP_HDR_WORDS);
                     state_r <= (processMode == TWP_MODE_RAW) ? TWP_RAW : TWP_SCAN;
                  end
               end
            end
            // Raw copy of every sample
            TWP_RAW: begin
               if (!rdValid_r) begin
                  rdPtr_r <= rdPtr_r + AW'(1);
               end else begin
                  window_word_counter_r <= window_word_counter_r + AW'(1);
                  memWrite_r <= 1'b1; // RULE_11
                  memAddr_r <= wrAddr_r;
                  memData_r <= mkWord(TWP_FLAG_DATA, 16'(bufData[15:0]));
                  wrAddr_r <= wrAddr_r + AW'(1);
                  if (window_word_counter_r + AW'(1) == lastWord) begin
                     state_r <= TWP_CLOSE;
                  end
               end
            end
            // Search for a threshold crossing
            TWP_SCAN: begin
               if (!rdValid_r) begin
                  if (window_word_counter_r == lastWord) begin
                     state_r <= (pulseCnt_r == 3'h0) ? TWP_NOEV : TWP_CLOSE; // RULE_16
                  end else begin
                     rdPtr_r <= rdPtr_r + AW'(1);
                  end
               end else begin
                  window_word_counter_r <= window_word_counter_r + AW'(1);
                  pulseTimer_r <= pulseTimer_r + AW'(1); // RULE_12
                  samples_before_crossing_count_r <= samples_before_crossing_count_r + AW'(1);
                  if (crossing && pulseCnt_r < 3'(TWP_MAX_PULSES)) begin
                     memWrite_r <= 1'b1; // RULE_13
                     memAddr_r <= wrAddr_r;
                     memData_r <= mkWord(TWP_FLAG_PULSE,
                        {4'h0, pulseIdx_r, pulseTimer_r[TWP_POS_W-1:0]}); // RULE_04
                     wrAddr_r <= wrAddr_r + AW'(1);
                     // Back up by pre count or what is available
                     if (samples_before_crossing_count_r >= pre_sample_count) begin
                        rdPtr_r <= rdIdx_r - pre_sample_count; // RULE_14 RULE_19
                        preTarget_r <= pre_sample_count;
                     end else begin
                        rdPtr_r <= rdIdx_r - samples_before_crossing_count_r; // RULE_14
                        preTarget_r <= samples_before_crossing_count_r;
                     end
                     resume_r <= rdIdx_r;
                     pre_sample_counter_r <= '0;
                     post_sample_counter_r <= '0;
                     sum_r <= '0;
                     state_r <= TWP_PRE;
                  end
               end
            end
            // Sum the samples before the crossing
            TWP_PRE: begin
               if (pre_sample_counter_r == preTarget_r) begin
                  state_r <= TWP_POST; // RULE_15
                  // This slot issues a read; step on so the crossing is summed once
                  rdPtr_r <= rdPtr_r + AW'(1);
               end else if (!rdValid_r) begin
                  rdPtr_r <= rdPtr_r + AW'(1);
               end else begin
                  sum_r <= sum_r + TWP_SUM_W'(sample);
                  pre_sample_counter_r <= pre_sample_counter_r + AW'(1);
               end
            end
            // Sum the crossing sample and those after it
            TWP_POST: begin
               if (post_sample_counter_r == post_sample_count + AW'(1) ||
                  rdIdx_r == lastWord) begin
                  state_r <= TWP_PW1; // RULE_15
               end else if (!rdValid_r) begin
                  rdPtr_r <= rdPtr_r + AW'(1);
               end else begin
                  sum_r <= sum_r + TWP_SUM_W'(sample);
                  post_sample_counter_r <= post_sample_counter_r + AW'(1);
               end
            end
            // First data word of the pulse
            TWP_PW1: begin
               memWrite_r <= 1'b1;
               memAddr_r <= wrAddr_r;
               wrAddr_r <= wrAddr_r + AW'(1);
               if (processMode == TWP_MODE_TIME) begin
                  memData_r <= mkWord(TWP_FLAG_DATA, {2'h0, 6'h00, pulseMin[11:4]}); // RULE_07
               end else begin
                  memData_r <= mkWord(TWP_FLAG_DATA, sum_r[18:3]); // RULE_05
               end
               state_r <= TWP_PW2;
            end
            // Second data word, then resume the scan after the crossing
            TWP_PW2: begin
               memWrite_r <= 1'b1;
               memAddr_r <= wrAddr_r;
               wrAddr_r <= wrAddr_r + AW'(1);
               if (processMode == TWP_MODE_TIME) begin
                  memData_r <= mkWord(TWP_FLAG_DATA, {pulseMin[3:0], pulsePeak}); // RULE_07
               end else begin
                  memData_r <= mkWord(TWP_FLAG_DATA, {13'h0000, sum_r[2:0]}); // RULE_05
               end
               pulseIdx_r <= pulseIdx_r + 2'h1; // RULE_06
               pulseCnt_r <= pulseCnt_r + 3'h1;
               rdPtr_r <= resume_r + AW'(1);
               state_r <= TWP_SCAN;
            end
            // No crossing: fillers then end marker
            TWP_NOEV: begin
               memWrite_r <= 1'b1;
               memAddr_r <= wrAddr_r;
               memData_r <= TWP_FILLER; // RULE_03 RULE_08 RULE_09
               wrAddr_r <= wrAddr_r + AW'(1);
               if (wrAddr_r == AW'(TWP_HDR_WORDS + 1)) begin
                  state_r <= TWP_CLOSE;
               end
            end
            // End-of-record word
            TWP_CLOSE: begin
               memWrite_r <= 1'b1;
               memAddr_r <= wrAddr_r;
               memData_r <= (processMode == TWP_MODE_RAW) ? TWP_RAW_END : TWP_END_WORD; // RULE_06
               state_r <= TWP_DONE;
            end
            // Write header words last, flags depending on result
            default: begin
               memWrite_r <= 1'b1;
               memAddr_r <= wrAddr_r;
               wrAddr_r <= wrAddr_r + AW'(1);
               if (wrAddr_r > AW'(TWP_HDR_WORDS)) begin
                  wrAddr_r <= '0;
                  memWrite_r <= 1'b0;
               end else begin
                  case (wrAddr_r)
                     AW'(0): memData_r <= mkWord(TWP_FLAG_DATA, {TWP_TRIG_TAG, trig_r[26:16]}); // RULE_01
                     AW'(1): memData_r <= mkWord(TWP_FLAG_DATA, trig_r[15:0]); // RULE_01
                     AW'(2): memData_r <= mkWord(TWP_FLAG_DATA, {TWP_TS_TAG, ts_r[47:40]}); // RULE_02
                     AW'(3): memData_r <= mkWord(TWP_FLAG_DATA, ts_r[39:24]); // RULE_02
                     AW'(4): memData_r <= mkWord((pulseCnt_r == 3'h0 && processMode != TWP_MODE_RAW)
                        ? TWP_FLAG_NOEVT : TWP_FLAG_DATA, {8'h00, ts_r[23:16]}); // RULE_02 RULE_03
                     default: memData_r <= mkWord((pulseCnt_r == 3'h0 && processMode != TWP_MODE_RAW)
                        ? TWP_FLAG_NOEVT : TWP_FLAG_DATA, ts_r[15:0]); // RULE_03
                  endcase
                  if (wrAddr_r == AW'(TWP_HDR_WORDS - 1)) begin
                     state_r <= TWP_IDLE;
                     windowDone_r <= 1'b1;
                     rdPtr_r <= '0; // RULE_17
                     window_word_counter_r <= '0; // RULE_17
                  end
               end
            end
         endcase
         if (state_r == TWP_CLOSE) begin
            wrAddr_r <= '0;
         end
      end
   end

   // Ready-window count; a simultaneous up and down cancel
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hostCnt_r <= '0;
      end else if (windowDone_r && !hostWindowTaken) begin
         hostCnt_r <= hostCnt_r + CW'(1); // RULE_18
      end else if (!windowDone_r && hostWindowTaken && hostCnt_r != '0) begin
         hostCnt_r <= hostCnt_r - CW'(1); // RULE_18
      end
   end

   // Assertions
   counter_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      windowDone_r |=> window_word_counter_r == '0) else $error("counter not cleared"); // RULE_17
   host_up_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      windowDone_r && !hostWindowTaken |=> hostCnt_r == $past(hostCnt_r) + CW'(1))
      else $error("ready count missed"); // RULE_18
   pulse_hdr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == TWP_SCAN && crossing && pulseCnt_r < 3'h4 |=> memWrite_r &&
      memData_r[17:16] == TWP_FLAG_PULSE) else $error("pulse header missing"); // RULE_04
   pulse_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pulseCnt_r <= 3'h4) else $error("too many pulses"); // RULE_06
   pre_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == TWP_PRE |-> pre_sample_counter_r <= preTarget_r)
      else $error("pre count overrun"); // RULE_15
   timer_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == TWP_SCAN && rdValid_r |=> pulseTimer_r == $past(pulseTimer_r) + AW'(1))
      else $error("timer not counting"); // RULE_12
   noev_fill_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == TWP_NOEV |=> memData_r == TWP_FILLER) else $error("filler wrong"); // RULE_03
   dispatch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == TWP_IDLE && windowPending |=> state_r == TWP_HDR)
      else $error("no dispatch"); // RULE_10
   cov_pulse_c: cover property (@(posedge ref_clk) state_r == TWP_PW2);
   cov_noev_c: cover property (@(posedge ref_clk) state_r == TWP_NOEV);
   cov_raw_c: cover property (@(posedge ref_clk) state_r == TWP_RAW && rdValid_r);

   assign window_read_pointer = rdPtr_r;
   assign windowDone = windowDone_r;
   assign memWrite = memWrite_r;
   assign memAddr = memAddr_r;
   assign memData = memData_r;
   assign host_ready_window_count = hostCnt_r;
endmodule

// >>> rtl/twp_pulse_track.sv
/*
 Peak and minimum tracker for one pulse; feeds the timing-mode record words.
 Assumes samples arrive one per clock while valid is high, cleared at each pulse start.
*/
`timescale 1ns/1ps
module twp_pulse_track
   import twp_pkg::*;
#(
   parameter int SW = TWP_SAMPLE_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control
   input wire logic clear,
   input wire logic valid,
   input wire logic [SW-1:0] sample,
   // Results
   output logic [SW-1:0] pulsePeak,
   output logic [SW-1:0] pulseMin
);
   logic [SW-1:0] peak_r; // Largest sample since clear
   logic [SW-1:0] min_r;  // Smallest sample since clear
   // Track extremes
   always_ff @(posedge ref_clk) begin
      if (!rst_n || clear) begin
         peak_r <= '0;
         min_r <= '1;
      end else if (valid) begin
         if (sample > peak_r) begin
            peak_r <= sample;
         end
         if (sample < min_r) begin
            min_r <= sample;
         end
      end
   end
   assign pulsePeak = peak_r;
   assign pulseMin = min_r;
endmodule

// >>> verif/trigger_window_processor_tb_top.sv
/*
 Self-checking bench for the window processor: raw, empty, sum and timing windows.
 Assumes the buffer model holds one window at address zero.
*/
`timescale 1ns/1ps
module trigger_window_processor_tb_top;
   import twp_pkg::*;
   localparam logic [26:0] TRIG = 27'h5A5A5A5;
   localparam logic [47:0] TS = 48'h9ABCDEF01234;
   localparam logic [11:0] THR = 12'h064;
   logic refClk, rstN, windowPending, hostWindowTaken, windowDone, memWrite;
   logic [1:0] processMode;
   logic [10:0] windowSamples, preCount, postCount, readPtr, memAddr, hostCount;
   logic [17:0] bufData, memData;
   logic [17:0] rec [0:2047];
   int num_errors = 0;
   int comparisons = 0;
   int expCount = 0;

   twp_core u_twp_core (.ref_clk(refClk), .rst_n(rstN), .processMode(processMode),
      .windowSamples(windowSamples), .pre_sample_count(preCount),
      .post_sample_count(postCount), .energy_threshold(THR), .windowPending(windowPending),
      .bufData(bufData), .window_read_pointer(readPtr), .windowDone(windowDone),
      .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
      .hostWindowTaken(hostWindowTaken), .host_ready_window_count(hostCount));
   twp_buffer_model u_twp_buffer_model (.ref_clk(refClk), .window_read_pointer(readPtr),
      .bufData(bufData), .hostWindowTaken(hostWindowTaken));

   // Captures every processing-memory write
   always @(posedge refClk) begin
      if (memWrite === 1'h1) rec[memAddr] <= memData;
   end

   // Counts and reports one comparison
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Loads header and a flat background of n samples
   task automatic load(input int n);
      u_twp_buffer_model.put_header(TRIG, TS);
      for (int i = 0; i < n; i++) put_sample(i, n, 12'h00A);
   endtask

   // Last sample carries its own tag
   task automatic put_sample(input int i, input int n, input logic [11:0] v);
      u_twp_buffer_model.put(TWP_HDR_WORDS + i, {2'h0, (i == n - 1) ? 3'h1 : 3'h0, 1'h0, v});
   endtask

   // Starts one window and waits for its completion
   task automatic run_window(input twp_mode_t mode, input int n);
      int k;
      for (k = 0; k < 2048; k++) rec[k] = 'x;
      @(negedge refClk);
      processMode = mode;
      windowSamples = 11'(n);
      windowPending = 1'h1;
      @(negedge refClk);
      windowPending = 1'h0;
      k = 0;
      while (windowDone !== 1'h1 && k < 4000) begin
         @(negedge refClk);
         k++;
      end
      check(18'(windowDone), 18'h1);
      expCount++;
      repeat (2) @(negedge refClk);
      check(18'(readPtr), 18'h0);
      check(18'(hostCount), 18'(expCount));
   endtask

   // Trigger number and time stamp words
   task automatic chk_hdr(input logic [1:0] f);
      check(rec[0], {2'h0, TWP_TRIG_TAG, TRIG[26:16]});
      check(rec[1], {2'h0, TRIG[15:0]});
      check(rec[2], {2'h0, TWP_TS_TAG, TS[47:40]});
      check(rec[3], {2'h0, TS[39:24]});
      check(rec[4], {f, 8'h00, TS[23:16]});
      check(rec[5], {f, TS[15:0]});
   endtask

   // Pulse header: tag, index, crossing position (timer may count the crossing itself)
   task automatic chk_pulse(input int i, input int k);
      logic [17:0] h;
      h = rec[6 + 3 * i];
      check({h[17:10], 10'h0}, {2'h2, 4'h0, 2'(i), 10'h0});
      check({17'h0, (h[9:0] !== 10'(k)) && (h[9:0] !== 10'(k + 1))}, 18'h0);
   endtask

   // Header plus the sum split over two words
   task automatic chk_sum(input int i, input int k, input logic [18:0] s);
      chk_pulse(i, k);
      check(rec[7 + 3 * i], {2'h0, s[18:3]});
      check(rec[8 + 3 * i], {2'h0, 13'h0, s[2:0]});
   endtask

   // Raw copy of eight samples
   task automatic test_raw();
      load(8);
      for (int i = 0; i < 8; i++) put_sample(i, 8, 12'(i * 37 + 5));
      run_window(TWP_MODE_RAW, 8);
      chk_hdr(TWP_FLAG_DATA);
      for (int i = 0; i < 8; i++) check({6'h0, rec[6 + i][11:0]}, 18'(i * 37 + 5));
      check(rec[14], TWP_RAW_END);
   endtask

   // No crossing in both pulse modes; one sample sits exactly on the threshold
   task automatic test_noevent();
      for (int m = 1; m < 3; m++) begin
         load(12);
         put_sample(5, 12, THR);
         run_window(twp_mode_t'(m), 12);
         chk_hdr(TWP_FLAG_NOEVT);
         check(rec[6], TWP_FILLER);
         check(rec[7], TWP_FILLER);
         check(rec[8], TWP_END_WORD);
         check(rec[9], 'x);
      end
   endtask

   // Five crossings, the first with a short lead-in; the fifth must be dropped
   task automatic test_sum_four();
      int k [5] = '{1, 10, 20, 28, 35};
      load(40);
      for (int i = 0; i < 5; i++) put_sample(k[i], 40, 12'(200 + 16 * i));
      run_window(TWP_MODE_SUM, 40);
      chk_hdr(TWP_FLAG_DATA);
      for (int i = 0; i < 4; i++) begin
         chk_sum(i, k[i], 19'(((k[i] < 3) ? k[i] : 3) * 10 + 200 + 16 * i + 20));
      end
      check(rec[18], TWP_END_WORD);
      check(rec[19], 'x);
   endtask

   // Lead-in equal to the pre count, then the timing record
   task automatic test_equal_timing();
      load(16);
      put_sample(3, 16, 12'h12C);
      run_window(TWP_MODE_SUM, 16);
      chk_sum(0, 3, 19'h15E);
      check(rec[9], TWP_END_WORD);
      put_sample(3, 16, 12'h00A);
      put_sample(5, 16, 12'h3A5);
      run_window(TWP_MODE_TIME, 16);
      chk_pulse(0, 5);
      check(rec[7], 18'h00000);
      check(rec[8], {2'h0, 4'hA, 12'h3A5});
      check(rec[9], TWP_END_WORD);
   endtask

   // Host drains every window, then one extra take at zero is ignored
   task automatic test_host();
      int n;
      n = expCount;
      for (int i = 0; i <= n; i++) u_twp_buffer_model.take_window();
      @(negedge refClk);
      check(18'(hostCount), 18'h0);
   endtask

   // Prints the verdict and ends the run
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // 40 MHz clock
   initial begin
      refClk = 1'h0;
      forever #12.5 refClk = ~refClk;
   end

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (30000) @(posedge refClk);
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
      conclude();
   end

   // Main sequence
   initial begin
      rstN = 1'h0;
      windowPending = 1'h0;
      processMode = 2'h0;
      windowSamples = 11'h0;
      preCount = 11'h003;
      postCount = 11'h002;
      repeat (8) @(negedge refClk);
      rstN = 1'h1;
      test_raw();
      test_noevent();
      test_sum_four();
      test_equal_timing();
      test_host();
      conclude();
   end
endmodule

// >>> verif/twp_buffer_model.sv
/*
 Secondary buffer and formatter stand-in for the window processor bench.
 Assumes the core reads one window from address zero and takes bufData one clock later.
*/
`timescale 1ns/1ps
module twp_buffer_model
   import twp_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Buffer read side
   input wire logic [10:0] window_read_pointer,
   output logic [TWP_WORD_W-1:0] bufData,
   // Formatter handshake
   output logic hostWindowTaken
);
   // Window storage: header words, then samples
   logic [TWP_WORD_W-1:0] mem [0:2047];

   // Registered read, answers the address a clock later
   always @(posedge ref_clk) begin
      bufData <= mem[window_read_pointer];
   end

   // Stores one word
   task automatic put(input int a, input logic [17:0] w);
      mem[a] = w;
   endtask

   // Time stamp in 12-bit pieces, trigger number in two halves
   task automatic put_header(input logic [26:0] trig, input logic [47:0] ts);
      put(0, {2'h0, 4'h8, ts[47:36]});
      put(1, {2'h0, 4'h8, ts[35:24]});
      put(2, {2'h0, 4'h8, ts[23:12]});
      put(3, {2'h0, 4'h8, ts[11:0]});
      put(4, {2'h0, 3'h2, trig[26:14]});
      put(5, {2'h0, 2'h1, trig[13:0]});
   endtask

   // One-cycle pulse once the host has read a window
   task automatic take_window();
      @(negedge ref_clk);
      hostWindowTaken = 1'h1;
      @(negedge ref_clk);
      hostWindowTaken = 1'h0;
   endtask

   // Quiet outputs at time zero
   initial begin
      hostWindowTaken = 1'h0;
   end
endmodule
